// ===== include/rsc_pkg.sv
/*
 Shared constants and types of the radio state controller.
 Assumes clk is the crystal clock, so cycle figures are crystal periods.
*/
package rsc_pkg;
   // Settling counts in crystal cycles
   localparam logic [19:0] IDLE_RX_CYC   = 20'h007A1;
   localparam logic [19:0] IDLE_TX_CYC   = 20'h007A2;
   localparam logic [19:0] RX_TX_CYC     = 20'h0030E;
   localparam logic [19:0] RX_IDLE_CYC   = 20'h00002;
   localparam logic [19:0] MAN_CAL_CYC   = 20'h0011B;
   localparam logic [19:0] XOSC_START    = 20'h00040;
   // Wake timer base divider, last count 749 of a divide by 750
   localparam logic [9:0]  WAKE_DIV_LAST = 10'h2ED;
   // Command header bytes
   localparam logic [7:0]  CMD_RX   = 8'h01;
   localparam logic [7:0]  CMD_TX   = 8'h02;
   localparam logic [7:0]  CMD_FS   = 8'h03;
   localparam logic [7:0]  CMD_CAL  = 8'h04;
   localparam logic [7:0]  CMD_IDLE = 8'h05;
   localparam logic [7:0]  CMD_PD   = 8'h06;
   localparam logic [7:0]  CMD_WOR  = 8'h07;
   // Autocalibration policy codes
   localparam logic [1:0]  CAL_NEVER  = 2'h0;
   localparam logic [1:0]  CAL_START  = 2'h1;
   localparam logic [1:0]  CAL_RETURN = 2'h2;
   localparam logic [1:0]  CAL_FOURTH = 2'h3;
   // Destination codes after RX and TX
   localparam logic [1:0]  DEST_IDLE = 2'h0;
   localparam logic [1:0]  DEST_FS   = 2'h1;
   localparam logic [1:0]  DEST_TX   = 2'h2;
   localparam logic [1:0]  DEST_RX   = 2'h3;

   typedef enum logic [2:0] {
      ST_SLEEP, ST_WAKE, ST_IDLE, ST_TRANS, ST_RX, ST_TX, ST_FSON
   } rsc_state_t;
endpackage

// ===== logic/rsc_wake_timer.sv
/*
 Wake timer: divide-by-750 base tick, exponent prescaler, Event 0 and 1.
 Assumes one clock; in sleep the calibrated RC stands in at the same rate.
*/
`timescale 1ns/1ps
module rsc_wake_timer (
   input  wire logic        clk,
   input  wire logic        nrst,
   input  wire logic        run,
   input  wire logic [15:0] mantissa,
   input  wire logic [1:0]  exponent,
   input  wire logic [3:0]  settle,
   output logic             tick,
   output logic             event0,
   output logic             event1
);
   logic [9:0]  divCnt, next_divCnt;
   logic [14:0] preCnt, next_preCnt;
   logic [15:0] manCnt, next_manCnt;
   logic [4:0]  setCnt, next_setCnt;
   logic        next_tick, next_event0, next_event1;
   logic [14:0] preLast;

   // Counter chain: base tick, prescale unit, period, settle delay
   always_comb begin
      preLast     = 15'(({15'h0000, 1'b1} << (5 * exponent)) - 16'h0001);
      next_divCnt = (divCnt == rsc_pkg::WAKE_DIV_LAST) ? 10'h000 : divCnt + 10'h001;
      next_tick   = (divCnt == rsc_pkg::WAKE_DIV_LAST);
      next_preCnt = preCnt;
      next_manCnt = manCnt;
      next_setCnt = setCnt;
      next_event0 = 1'b0;
      next_event1 = 1'b0;
      if (next_tick) begin
         // Settle count first, so that a new Event 0 reload wins
         if (setCnt != 5'h00) begin
            next_setCnt = setCnt - 5'h01;
            next_event1 = (setCnt == 5'h01);
         end
         next_preCnt = (preCnt >= preLast) ? 15'h0000 : preCnt + 15'h0001;
         if (preCnt >= preLast) begin
            if (manCnt + 16'h0001 >= mantissa) begin
               next_manCnt = 16'h0000;
               next_event0 = 1'b1;
               next_setCnt = {1'b0, settle} + 5'h01;
            end else begin
               next_manCnt = manCnt + 16'h0001;
            end
         end
      end
      if (!run) begin
         next_preCnt = 15'h0000;
         next_manCnt = 16'h0000;
         next_setCnt = 5'h00;
         next_event0 = 1'b0;
         next_event1 = 1'b0;
      end
   end

   // Registers
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         divCnt <= 10'h000;
         preCnt <= 15'h0000;
         manCnt <= 16'h0000;
         setCnt <= 5'h00;
         tick   <= 1'b0;
         event0 <= 1'b0;
         event1 <= 1'b0;
      end else begin
         divCnt <= next_divCnt;
         preCnt <= next_preCnt;
         manCnt <= next_manCnt;
         setCnt <= next_setCnt;
         tick   <= next_tick;
         event0 <= next_event0;
         event1 <= next_event1;
      end
   end
endmodule

// ===== logic/rsc_radio_ctrl.sv
/*
 Radio state controller: strobes, sleep, wake cycle, calibration, settling.
 Assumes commands arrive as synchronous header bytes; chip select is a pin.
*/
`timescale 1ns/1ps
module rsc_radio_ctrl #(
   parameter logic [19:0] FsCalCycles = 20'h0497F
) (
   input  wire logic        clk,
   input  wire logic        nrst,
   input  wire logic        chipSelectLow,
   input  wire logic        cmdValid,
   input  wire logic [7:0]  cmdByte,
   input  wire logic [1:0]  autocalPolicy,
   input  wire logic [1:0]  afterRxState,
   input  wire logic [1:0]  afterTxState,
   input  wire logic [1:0]  clearChannelRule,
   input  wire logic        channelClear,
   input  wire logic        packetReceived,
   input  wire logic        syncFound,
   input  wire logic        packetSent,
   input  wire logic [7:0]  rxTimeLimit,
   input  wire logic [15:0] symbolCycles,
   input  wire logic [2:0]  txRampSetting,
   input  wire logic [7:0]  wakePeriodHigh,
   input  wire logic [7:0]  wakePeriodLow,
   input  wire logic [1:0]  wakePeriodExponent,
   input  wire logic [3:0]  wakeSettleTimeout,
   input  wire logic        rcAutoCalEnable,
   input  wire logic [6:0]  rcMeasA,
   input  wire logic [6:0]  rcMeasB,
   input  wire logic [6:0]  rcCalValueA,
   input  wire logic [6:0]  rcCalValueB,
   output logic             regulatorOn,
   output logic             xoscOn,
   output logic             fifoFlush,
   output logic             rxOn,
   output logic             txOn,
   output logic             synthOn,
   output logic             calActive,
   output logic             worActive,
   output logic             rcCalActive,
   output logic [6:0]       rcCalResultA,
   output logic [6:0]       rcCalResultB,
   output logic [6:0]       rcTrimA,
   output logic [6:0]       rcTrimB,
   output logic [2:0]       stateCode
);
   rsc_pkg::rsc_state_t state, next_state, target, next_target;
   logic [19:0] waitCnt, next_waitCnt;
   logic [2:0]  csSync;
   logic        csLowStable, csLowPrev;
   logic        sleepArmed, next_sleepArmed, next_worActive;
   logic        transCal, next_transCal;
   logic [1:0]  returnCnt, next_returnCnt;
   logic [7:0]  rxTimer, next_rxTimer;
   logic        next_regulatorOn, next_xoscOn, next_fifoFlush, next_rxOn;
   logic        next_txOn, next_synthOn, next_calActive, next_rcCalActive;
   logic [6:0]  next_rcCalResultA, next_rcCalResultB, next_rcTrimA, next_rcTrimB;
   logic        strobeRx, strobeTx, strobeFs, strobeCal, strobeIdle, strobePd;
   logic        strobeWor, csFall, csReleased, ccaOk, rxExpire;
   logic        doDest, destFromTx, retCal;
   logic [1:0]  destCode;
   logic [19:0] quarterSym, rampExtra, calCyc;
   logic        tick, event0, event1;

   // Wake timer with Event 0 and Event 1
   rsc_wake_timer u_wake (
      .clk      (clk),
      .nrst     (nrst),
      .run      (worActive),
      .mantissa ({wakePeriodHigh, wakePeriodLow}),
      .exponent (wakePeriodExponent),
      .settle   (wakeSettleTimeout),
      .tick     (tick),
      .event0   (event0),
      .event1   (event1)
   );

   // Chip select pin: three flops, change taken when last two agree
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         csSync      <= 3'h7;
         csLowStable <= 1'b1;
         csLowPrev   <= 1'b1;
      end else begin
         csSync    <= {csSync[1:0], chipSelectLow};
         csLowPrev <= csLowStable;
         if (csSync[1] == csSync[2]) begin
            csLowStable <= csSync[2];
         end
      end
   end

   // Strobe decode from one header byte
   always_comb begin
      strobeRx   = cmdValid && (cmdByte == rsc_pkg::CMD_RX);
      strobeTx   = cmdValid && (cmdByte == rsc_pkg::CMD_TX);
      strobeFs   = cmdValid && (cmdByte == rsc_pkg::CMD_FS);
      strobeCal  = cmdValid && (cmdByte == rsc_pkg::CMD_CAL);
      strobeIdle = cmdValid && (cmdByte == rsc_pkg::CMD_IDLE);
      strobePd   = cmdValid && (cmdByte == rsc_pkg::CMD_PD);
      strobeWor  = cmdValid && (cmdByte == rsc_pkg::CMD_WOR);
      csFall     = csLowPrev && !csLowStable;
      csReleased = csLowStable;
      ccaOk      = (clearChannelRule == 2'h0) || channelClear;
      rxExpire   = (rxTimeLimit != 8'h00) && (rxTimer >= rxTimeLimit) && !syncFound;
      quarterSym = {6'h00, symbolCycles[15:2]};
      rampExtra  = 20'(txRampSetting) * {7'h00, symbolCycles[15:3]};
      calCyc     = FsCalCycles;
      retCal     = (autocalPolicy == rsc_pkg::CAL_RETURN) ||
                   ((autocalPolicy == rsc_pkg::CAL_FOURTH) && (returnCnt == 2'h3));
   end

   // Main state machine next values
   always_comb begin
      next_state      = state;
      next_target     = target;
      next_waitCnt    = waitCnt;
      next_sleepArmed = sleepArmed;
      next_worActive  = worActive;
      next_transCal   = transCal;
      next_returnCnt  = returnCnt;
      next_rxTimer    = rxTimer;
      doDest          = 1'b0;
      destFromTx      = 1'b0;
      destCode        = rsc_pkg::DEST_IDLE;
      case (state)
         rsc_pkg::ST_SLEEP: begin
            if (csFall || (worActive && event0)) begin
               next_state   = rsc_pkg::ST_WAKE;
               next_waitCnt = rsc_pkg::XOSC_START;
            end
         end
         rsc_pkg::ST_WAKE: begin
            next_waitCnt = waitCnt - 20'h00001;
            if (waitCnt == 20'h00001) begin
               next_state = rsc_pkg::ST_IDLE;
            end
         end
         rsc_pkg::ST_IDLE: begin
            if (strobePd || strobeWor) begin
               next_sleepArmed = 1'b1;
               next_worActive  = strobeWor;
            end
            if (strobeRx || (worActive && event1)) begin
               next_state    = rsc_pkg::ST_TRANS;
               next_target   = rsc_pkg::ST_RX;
               next_transCal = (autocalPolicy == rsc_pkg::CAL_START);
               next_waitCnt  = rsc_pkg::IDLE_RX_CYC + (next_transCal ? calCyc : 20'h00000);
            end else if (strobeTx || strobeFs) begin
               next_state    = rsc_pkg::ST_TRANS;
               next_target   = strobeTx ? rsc_pkg::ST_TX : rsc_pkg::ST_FSON;
               next_transCal = (autocalPolicy == rsc_pkg::CAL_START);
               next_waitCnt  = rsc_pkg::IDLE_TX_CYC + (next_transCal ? calCyc : 20'h00000);
            end else if (strobeCal) begin
               next_state    = rsc_pkg::ST_TRANS;
               next_target   = rsc_pkg::ST_IDLE;
               next_transCal = 1'b1;
               next_waitCnt  = rsc_pkg::MAN_CAL_CYC + calCyc;
            end else if (sleepArmed && csReleased) begin
               next_state      = rsc_pkg::ST_SLEEP;
               next_sleepArmed = 1'b0;
            end
         end
         rsc_pkg::ST_TRANS: begin
            next_waitCnt = waitCnt - 20'h00001;
            if (waitCnt == 20'h00001) begin
               next_state    = target;
               next_transCal = 1'b0;
               next_rxTimer  = 8'h00;
            end
         end
         rsc_pkg::ST_RX: begin
            if (tick && (rxTimer != 8'hFF)) begin
               next_rxTimer = rxTimer + 8'h01;
            end
            if (packetReceived) begin
               doDest   = 1'b1;
               destCode = afterRxState;
            end else if (rxExpire) begin
               next_state = worActive ? rsc_pkg::ST_SLEEP : rsc_pkg::ST_IDLE;
            end else if ((strobeTx || strobeFs) && ccaOk) begin
               next_state   = rsc_pkg::ST_TRANS;
               next_target  = strobeTx ? rsc_pkg::ST_TX : rsc_pkg::ST_FSON;
               next_waitCnt = rsc_pkg::RX_TX_CYC;
            end
         end
         rsc_pkg::ST_TX: begin
            if (strobeRx) begin
               next_state   = rsc_pkg::ST_TRANS;
               next_target  = rsc_pkg::ST_RX;
               next_waitCnt = rsc_pkg::RX_TX_CYC + quarterSym + rampExtra;
            end else if (packetSent) begin
               doDest     = 1'b1;
               destFromTx = 1'b1;
               destCode   = afterTxState;
            end
         end
         rsc_pkg::ST_FSON: begin
            if (strobeTx) begin
               next_state = rsc_pkg::ST_TX;
            end else if (strobeRx) begin
               next_state   = rsc_pkg::ST_TRANS;
               next_target  = rsc_pkg::ST_RX;
               next_waitCnt = rsc_pkg::RX_TX_CYC;
            end
         end
         default: begin
            next_state = rsc_pkg::ST_IDLE;
         end
      endcase
      // Destination after a finished packet
      if (doDest) begin
         next_rxTimer = 8'h00;
         case (destCode)
            rsc_pkg::DEST_IDLE: begin
               next_state     = rsc_pkg::ST_TRANS;
               next_target    = rsc_pkg::ST_IDLE;
               next_transCal  = retCal;
               next_returnCnt = returnCnt + 2'h1;
               next_waitCnt   = (destFromTx ? quarterSym + rampExtra + 20'h00001
                                            : rsc_pkg::RX_IDLE_CYC)
                                + (retCal ? calCyc : 20'h00000);
            end
            rsc_pkg::DEST_FS: begin
               next_state   = destFromTx ? rsc_pkg::ST_FSON : rsc_pkg::ST_TRANS;
               next_target  = rsc_pkg::ST_FSON;
               next_waitCnt = rsc_pkg::RX_TX_CYC;
            end
            rsc_pkg::DEST_TX: begin
               next_state   = destFromTx ? rsc_pkg::ST_TX : rsc_pkg::ST_TRANS;
               next_target  = rsc_pkg::ST_TX;
               next_waitCnt = rsc_pkg::RX_TX_CYC;
            end
            default: begin
               next_state   = destFromTx ? rsc_pkg::ST_TRANS : rsc_pkg::ST_RX;
               next_target  = rsc_pkg::ST_RX;
               next_waitCnt = rsc_pkg::RX_TX_CYC + quarterSym + rampExtra;
            end
         endcase
      end
      // Idle strobe overrides everything outside sleep, no calibration, ends wake cycling
      if (strobeIdle && (state != rsc_pkg::ST_SLEEP)) begin
         next_state      = rsc_pkg::ST_IDLE;
         next_transCal   = 1'b0;
         next_worActive  = 1'b0;
         next_sleepArmed = 1'b0;
      end
   end

   // Output and RC calibration next values
   always_comb begin
      next_regulatorOn  = (next_state != rsc_pkg::ST_SLEEP);
      next_xoscOn       = (next_state != rsc_pkg::ST_SLEEP);
      next_fifoFlush    = (next_state == rsc_pkg::ST_SLEEP);
      next_rxOn         = (next_state == rsc_pkg::ST_RX);
      next_txOn         = (next_state == rsc_pkg::ST_TX);
      next_synthOn      = (next_state == rsc_pkg::ST_FSON) || next_rxOn || next_txOn;
      next_calActive    = (next_state == rsc_pkg::ST_TRANS) && next_transCal;
      next_rcCalActive  = rcAutoCalEnable && (next_state != rsc_pkg::ST_SLEEP) &&
                          (next_state != rsc_pkg::ST_WAKE);
      next_rcCalResultA = rcCalActive ? rcMeasA : rcCalResultA;
      next_rcCalResultB = rcCalActive ? rcMeasB : rcCalResultB;
      next_rcTrimA      = rcAutoCalEnable ? rcCalResultA : rcCalValueA;
      next_rcTrimB      = rcAutoCalEnable ? rcCalResultB : rcCalValueB;
   end

   // Registers
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state        <= rsc_pkg::ST_IDLE;
         target       <= rsc_pkg::ST_IDLE;
         waitCnt      <= 20'h00000;
         sleepArmed   <= 1'b0;
         worActive    <= 1'b0;
         transCal     <= 1'b0;
         returnCnt    <= 2'h0;
         rxTimer      <= 8'h00;
         regulatorOn  <= 1'b1;
         xoscOn       <= 1'b1;
         fifoFlush    <= 1'b0;
         rxOn         <= 1'b0;
         txOn         <= 1'b0;
         synthOn      <= 1'b0;
         calActive    <= 1'b0;
         rcCalActive  <= 1'b0;
         rcCalResultA <= 7'h00;
         rcCalResultB <= 7'h00;
         rcTrimA      <= 7'h00;
         rcTrimB      <= 7'h00;
         stateCode    <= 3'h2;
      end else begin
         state        <= next_state;
         target       <= next_target;
         waitCnt      <= next_waitCnt;
         sleepArmed   <= next_sleepArmed;
         worActive    <= next_worActive;
         transCal     <= next_transCal;
         returnCnt    <= next_returnCnt;
         rxTimer      <= next_rxTimer;
         regulatorOn  <= next_regulatorOn;
         xoscOn       <= next_xoscOn;
         fifoFlush    <= next_fifoFlush;
         rxOn         <= next_rxOn;
         txOn         <= next_txOn;
         synthOn      <= next_synthOn;
         calActive    <= next_calActive;
         rcCalActive  <= next_rcCalActive;
         rcCalResultA <= next_rcCalResultA;
         rcCalResultB <= next_rcCalResultB;
         rcTrimA      <= next_rcTrimA;
         rcTrimB      <= next_rcTrimB;
         stateCode    <= next_state;
      end
   end

   // Checks
   chk_sleep_power: assert property (@(posedge clk) disable iff (!nrst)
      (state == rsc_pkg::ST_SLEEP) && $past(state == rsc_pkg::ST_SLEEP)
      |-> !regulatorOn && !xoscOn)
      else $error("regulator on in sleep");
   chk_sleep_flush: assert property (@(posedge clk) disable iff (!nrst)
      $rose(state == rsc_pkg::ST_SLEEP) |-> fifoFlush)
      else $error("fifo not flushed in sleep");
   chk_cs_wake: assert property (@(posedge clk) disable iff (!nrst)
      (state == rsc_pkg::ST_SLEEP) && csFall |=> (state == rsc_pkg::ST_WAKE)
      ##64 (state == rsc_pkg::ST_IDLE))
      else $error("no wake on chip select");
   chk_idle_force: assert property (@(posedge clk) disable iff (!nrst)
      strobeIdle && (state != rsc_pkg::ST_SLEEP) |=> (state == rsc_pkg::ST_IDLE) && !calActive)
      else $error("idle strobe ignored");
   chk_tx_abort: assert property (@(posedge clk) disable iff (!nrst)
      (state == rsc_pkg::ST_TX) && strobeRx && !strobeIdle
      |=> (state == rsc_pkg::ST_TRANS) && (target == rsc_pkg::ST_RX))
      else $error("tx not aborted");
   chk_cca_block: assert property (@(posedge clk) disable iff (!nrst)
      (state == rsc_pkg::ST_RX) && (strobeTx || strobeFs) && !ccaOk && !strobeIdle
      && !packetReceived && !rxExpire |=> (state == rsc_pkg::ST_RX))
      else $error("left rx on busy channel");
   chk_rx_settle: assert property (@(posedge clk) disable iff (!nrst)
      (state == rsc_pkg::ST_IDLE) && strobeRx && !strobeIdle
      && (autocalPolicy != rsc_pkg::CAL_START) |=> (waitCnt == 20'h007A1))
      else $error("idle to rx count wrong");
   chk_pd_idle_only: assert property (@(posedge clk) disable iff (!nrst)
      (state == rsc_pkg::ST_RX) && !sleepArmed |=> !sleepArmed)
      else $error("power down armed outside idle");
   chk_timeout_dest: assert property (@(posedge clk) disable iff (!nrst)
      (state == rsc_pkg::ST_RX) && rxExpire && !packetReceived && !strobeIdle && worActive
      |=> (state == rsc_pkg::ST_SLEEP))
      else $error("timeout did not return to sleep");
endmodule

// ===== verif/rsc_host_model.sv
/*
 Host side model: sends command strobes and drives chip select.
 Assumes the bench calls its tasks from one process, one at a time.
*/
`timescale 1ns/1ps
module rsc_host_model (
   input  wire logic clk,
   output logic      chipSelectLow,
   output logic      cmdValid,
   output logic [7:0] cmdByte
);
   // Idle bus at time zero, chip released
   initial begin
      chipSelectLow = 1'b1;
      cmdValid = 1'b0;
      cmdByte = 8'h00;
   end
   // One header byte per strobe, valid for a single edge
   task automatic strobe(input logic [7:0] code);
      @(posedge clk);
      #1 cmdValid = 1'b1;
      cmdByte = code;
      @(posedge clk);
      #1 cmdValid = 1'b0;
      cmdByte = ~code; // Stale byte scrambled
   endtask
   // Select changes just after an edge, then the pin synchroniser settles
   task automatic select(input logic lvl);
      @(posedge clk);
      #1 chipSelectLow = lvl;
      repeat (4) @(posedge clk);
      #1;
   endtask
endmodule

// ===== verif/rsc_radio_ctrl_tb_top.sv
/*
 Bench for the radio state controller: table of strobes, then odd cases.
 Assumes the host model in verif and calibration shortened to 20 cycles.
*/
`timescale 1ns/1ps
module rsc_radio_ctrl_tb_top;
   typedef struct {logic [1:0] pol; logic [7:0] cmd; logic [2:0] st; int cyc;} rsc_row_t;
   logic       clk = 1'b0, nrst = 1'b0, chanClear = 1'b0, pktRx = 1'b0, pktTx = 1'b0;
   logic [1:0] pol = 2'h0, aRx = 2'h0, aTx = 2'h0, ccRule = 2'h0;
   logic [7:0] rxLim = 8'h00;
   logic [6:0] measA = 7'h2A, measB = 7'h15, valA = 7'h00, valB = 7'h00, rcResA, rcResB;
   logic [6:0] rcTrimA, rcTrimB;
   logic [2:0] ramp = 3'h0;
   logic       syncF = 1'b0, rcEn = 1'b1, rxOn, txOn, synthOn, calAct, rcCalAct;
   logic [2:0] st;
   logic       regOn, xoOn, flush, worOn, csLow, cmdValid;
   logic [7:0] cmdByte;
   int         n_mismatch = 0, n_tests = 0, n;
   rsc_row_t   rows[7] = '{'{2'h0, rsc_pkg::CMD_RX, 3'h4, 1953},
      '{2'h0, rsc_pkg::CMD_TX, 3'h5, 1954}, '{2'h0, rsc_pkg::CMD_FS, 3'h6, 1954},
      '{2'h1, rsc_pkg::CMD_RX, 3'h4, 1973}, '{2'h1, rsc_pkg::CMD_TX, 3'h5, 1974},
      '{2'h2, rsc_pkg::CMD_RX, 3'h4, 1953}, '{2'h0, rsc_pkg::CMD_CAL, 3'h2, 303}};
   // Crystal clock
   always #20 clk = ~clk;
   rsc_host_model u_rsc_host_model (.clk(clk), .chipSelectLow(csLow), .cmdValid(cmdValid),
      .cmdByte(cmdByte));
   // Wake period of one tick keeps the run short
   rsc_radio_ctrl #(.FsCalCycles(20'h00014)) u_rsc_radio_ctrl (.clk(clk), .nrst(nrst),
      .chipSelectLow(csLow), .cmdValid(cmdValid), .cmdByte(cmdByte), .autocalPolicy(pol),
      .afterRxState(aRx), .afterTxState(aTx), .clearChannelRule(ccRule),
      .channelClear(chanClear), .packetReceived(pktRx), .syncFound(syncF),
      .packetSent(pktTx), .rxTimeLimit(rxLim), .symbolCycles(16'h0010),
      .txRampSetting(ramp), .wakePeriodHigh(8'h00), .wakePeriodLow(8'h01),
      .wakePeriodExponent(2'h0), .wakeSettleTimeout(4'h0), .rcAutoCalEnable(rcEn),
      .rcMeasA(measA), .rcMeasB(measB), .rcCalValueA(valA), .rcCalValueB(valB),
      .regulatorOn(regOn), .xoscOn(xoOn), .fifoFlush(flush), .rxOn(rxOn), .txOn(txOn),
      .synthOn(synthOn), .calActive(calAct), .worActive(worOn), .rcCalActive(rcCalAct),
      .rcCalResultA(rcResA), .rcCalResultB(rcResB), .rcTrimA(rcTrimA), .rcTrimB(rcTrimB),
      .stateCode(st));
   // Compare and count
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t got %h want %h", $time, got, exp);
      end
   endtask
   // Edges until a state shows, bounded
   task automatic waitSt(input logic [2:0] s, input int lim);
      n = 0;
      while (st !== s && n < lim) begin
         @(posedge clk);
         #1 n++;
      end
   endtask
   task automatic cyc(input int want);
      chk(8'(n >= want && n <= want + 1), 8'h01);
   endtask
   task automatic pulse(ref logic s);
      @(posedge clk);
      #1 s = 1'b1;
      @(posedge clk);
      #1 s = 1'b0;
   endtask
   task automatic results;
      $display("mismatches %0d comparisons %0d", n_mismatch, n_tests);
      if (n_mismatch == 0 && n_tests > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // Watchdog on a hang
   initial begin
      #(40 * 60000);
      n_mismatch++;
      results;
   end
   // Main sequence
   initial begin
      repeat (20) @(posedge clk);
      #1 nrst = 1'b1;
      chk(8'(st), 8'h02);
      foreach (rows[i]) begin
         pol = rows[i].pol;
         u_rsc_host_model.strobe(rows[i].cmd);
         chk(8'(st), 8'h03);
         chk(8'(calAct),
            8'(rows[i].pol == rsc_pkg::CAL_START || rows[i].cmd == rsc_pkg::CMD_CAL));
         waitSt(rows[i].st, 3000);
         cyc(rows[i].cyc);
         chk(8'({rxOn, txOn, synthOn}),
            8'({rows[i].st == 3'h4, rows[i].st == 3'h5, rows[i].st != 3'h2}));
         u_rsc_host_model.strobe(rsc_pkg::CMD_IDLE);
         chk(8'(st), 8'h02);
      end
      chk(8'({rcCalAct, rcTrimA}), 8'hAA);
      chk(8'(rcTrimB), 8'h15);
      chk(8'(rcResB), 8'h15);
      // Abort transmit, then the clear channel gate
      pol = 2'h0;
      u_rsc_host_model.strobe(rsc_pkg::CMD_TX);
      waitSt(3'h5, 3000);
      u_rsc_host_model.strobe(rsc_pkg::CMD_RX);
      waitSt(3'h4, 1000);
      cyc(786);
      ccRule = 2'h1;
      u_rsc_host_model.strobe(rsc_pkg::CMD_TX);
      waitSt(3'h5, 10);
      chk(8'(st), 8'h04);
      chanClear = 1'b1;
      u_rsc_host_model.strobe(rsc_pkg::CMD_TX);
      waitSt(3'h5, 1000);
      cyc(782);
      // Packet ends that restart the other direction
      aTx = rsc_pkg::DEST_RX;
      pulse(pktTx);
      waitSt(3'h4, 1000);
      cyc(786);
      aRx = rsc_pkg::DEST_TX;
      pulse(pktRx);
      waitSt(3'h5, 1000);
      cyc(782);
      aRx = rsc_pkg::DEST_IDLE;
      aTx = rsc_pkg::DEST_IDLE;
      // Sent packet returns to idle with calibration and ramp time
      pol = 2'h2;
      ramp = 3'h2;
      pulse(pktTx);
      waitSt(3'h2, 100);
      cyc(29);
      // Every fourth automatic return calibrates
      pol = 2'h3;
      for (int k = 0; k < 3; k++) begin
         u_rsc_host_model.strobe(rsc_pkg::CMD_RX);
         waitSt(3'h4, 3000);
         pulse(pktRx);
         waitSt(3'h2, 100);
         cyc(k == 2 ? 22 : 2);
      end
      aRx = rsc_pkg::DEST_FS;
      u_rsc_host_model.strobe(rsc_pkg::CMD_RX);
      waitSt(3'h4, 3000);
      pulse(pktRx);
      waitSt(3'h6, 1000);
      chk(8'(st), 8'h06);
      u_rsc_host_model.strobe(rsc_pkg::CMD_IDLE);
      // Receive timeout held off by sync, power down refused in receive
      rxLim = 8'h01;
      syncF = 1'b1;
      u_rsc_host_model.strobe(rsc_pkg::CMD_RX);
      waitSt(3'h4, 3000);
      u_rsc_host_model.strobe(rsc_pkg::CMD_PD);
      repeat (1600) @(posedge clk);
      #1 chk(8'(st), 8'h04);
      syncF = 1'b0;
      waitSt(3'h2, 900);
      chk(8'(n <= 752 && st == 3'h2), 8'h01);
      repeat (4) @(posedge clk);
      #1 chk(8'(st), 8'h02);
      // Power down on release, wake on select
      u_rsc_host_model.select(1'b0);
      u_rsc_host_model.strobe(rsc_pkg::CMD_PD);
      chk(8'(st), 8'h02);
      u_rsc_host_model.select(1'b1);
      waitSt(3'h0, 10);
      measA = 7'h33;
      chk(8'({regOn, xoOn, flush}), 8'h01);
      u_rsc_host_model.select(1'b0);
      chk(8'(rcResA), 8'h2A);
      waitSt(3'h2, 100);
      chk(8'(regOn), 8'h01);
      // Wake cycle, back to sleep after timeout
      u_rsc_host_model.strobe(rsc_pkg::CMD_WOR);
      u_rsc_host_model.select(1'b1);
      waitSt(3'h0, 10);
      chk(8'(worOn), 8'h01);
      waitSt(3'h4, 5000);
      chk(8'(st), 8'h04);
      waitSt(3'h0, 1000);
      chk(8'(st), 8'h00);
      u_rsc_host_model.select(1'b0);
      waitSt(3'h2, 100);
      u_rsc_host_model.strobe(rsc_pkg::CMD_IDLE);
      chk(8'({worOn, st}), 8'h02);
      chk(8'(rcTrimA), 8'h33);
      // Auto calibration off: host values drive the trims
      rcEn = 1'b0;
      valA = 7'h5A;
      valB = 7'h25;
      repeat (2) @(posedge clk);
      #1 chk(8'({rcCalAct, rcTrimA}), 8'h5A);
      chk(8'(rcTrimB), 8'h25);
      results;
   end
endmodule
